// *** pulse_counter_params.svh ***
// What this block does
// - shown value read-only pair: high word at 01h, low word at 02h
// - status reads 0000h valid, 0080h overflow, 0040h underflow
// - writable precounter at 04h/05h counts modulo divider, wrap steps main count
// - main counter readable and writable, high word 06h, low word 07h
// - 08h relay states bits 0..3, writes drive only those bits
// - 09h read-only task bit per relay, set once relay was activated
// - 11h aux input: 0 off, 1 hold counter, 2 set direction
// - 12h clear sources: all, external+bus, button+bus, bus only
// - 13h auto clear: 0 disabled, 1 enabled
// - 14h filter: 0 up to 10 kHz, 1..9 limit 10 Hz times code
// - 15h function: 0 add both inputs, 1 add first, subtract second
// - function 2 counts per quadrature cycle, 3 per quarter cycle
// - multiplier at 16h/17h, signed, range -99999 to 999999
// - shown value is main count times multiplier over divider
// - main count steps once every n counting events, n from 18h on
// - divider low word at 19h, combined range 1 to 999999
// - two's complement values; read 03h, write 06h single, 10h group
// - 04h..08h stay writable even when config writes are denied
`ifndef PULSE_COUNTER_PARAMS_SVH
`define PULSE_COUNTER_PARAMS_SVH
`define REG_SHOWN_HI 6'h01
`define REG_SHOWN_LO 6'h02
`define REG_STATUS 6'h03
`define REG_PRE_HI 6'h04
`define REG_PRE_LO 6'h05
`define REG_MAIN_HI 6'h06
`define REG_MAIN_LO 6'h07
`define REG_RELAY 6'h08
`define REG_TASK 6'h09
`define REG_AUX_FN 6'h11
`define REG_CLR_SEL 6'h12
`define REG_AUTO_CLR 6'h13
`define REG_FILTER 6'h14
`define REG_FUNC 6'h15
`define REG_MUL_HI 6'h16
`define REG_MUL_LO 6'h17
`define REG_DIV_HI 6'h18
`define REG_DIV_LO 6'h19
`define STATUS_VALID 16'h0000
`define STATUS_OVER 16'h0080
`define STATUS_UNDER 16'h0040
`define MUL_MIN (-32'sd99999)
`define MUL_MAX 32'sd999999
`define DIV_MIN 32'sd1
`define DIV_MAX 32'sd999999
`define SHOWN_MIN (-64'sd99999)
`define SHOWN_MAX 64'sd999999
`define MUL_RESET 32'h0000_0001
`define DIV_RESET 32'h0000_0001
`define AUX_MAX 16'h0002
`define CLR_MAX 16'h0003
`define AUTO_MAX 16'h0001
`define FILT_MAX 16'h0009
`define FUNC_MAX 16'h0003
`define FILT_BASE_HZ 10
`define FILT_FAST_HZ 10000
`define CLK_HZ 100000000
`endif

// *** pulse_counter_pkg.sv ***
package pulse_counter_pkg;
    typedef enum logic [1:0] {
        FN_ADD = 2'h0,
        FN_SUB = 2'h1,
        FN_QUAD1 = 2'h2,
        FN_QUAD4 = 2'h3
    } count_fn_t;
    typedef enum logic [1:0] {
        AUX_OFF = 2'h0,
        AUX_HOLD = 2'h1,
        AUX_DIR = 2'h2
    } aux_fn_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic a;
        logic b;
        logic aux;
        logic ext_clear;
        logic button_clear;
    } pulse_in_t;
endpackage : pulse_counter_pkg

// *** pulse_filter.sv ***
`timescale 1ns/100ps
`include "pulse_counter_params.svh"
// one input filter: the level must stay stable for hold_i + 1 cycles to pass
module pulse_filter #(
    parameter int W = 24
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] hold_i,
    input wire logic in_i,
    output logic out_o
);
    logic [W-1:0] cnt_r;
    logic raw_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            raw_r <= 1'b0;
            cnt_r <= '0;
            out_o <= 1'b0;
        end else if (ce_i) begin
            raw_r <= in_i;
            if (raw_r == out_o) begin
                cnt_r <= '0;
            end else if (cnt_r >= hold_i) begin
                out_o <= raw_r;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + W'(1);
            end
        end
    end
endmodule : pulse_filter

// *** pulse_counter.sv ***
`timescale 1ns/100ps
`include "pulse_counter_params.svh"
module pulse_counter #(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int FW = 24
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire pulse_counter_pkg::reg_req_t req_i,
    input wire pulse_counter_pkg::pulse_in_t pins_i,
    input wire logic cfg_write_en_i,
    input wire logic auto_clear_i,
    input wire logic [3:0] relay_fire_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic wr_reject_o,
    output logic [3:0] relay_o
);
    import pulse_counter_pkg::*;

    // ----------------
    // settings
    // ----------------
    aux_fn_t aux_fn_r;
    count_fn_t func_r;
    logic [1:0] clr_sel_r;
    logic auto_clr_r;
    logic [3:0] filt_r;
    logic [15:0] mul_hi_r, mul_lo_r, div_hi_r, div_lo_r;
    logic [15:0] pre_hi_r, pre_lo_r, main_hi_r, main_lo_r;
    logic [3:0] task_r;

    // two words into one signed value, lower address is upper half
    function automatic logic signed [31:0] pair(input logic [15:0] hi,
                                                input logic [15:0] lo);
        pair = signed'({hi, lo});
    endfunction : pair

    function automatic logic in_range(input logic signed [31:0] v,
                                      input logic signed [31:0] lo,
                                      input logic signed [31:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    logic signed [31:0] mul_v, div_v, pre_v, main_v;
    assign mul_v = pair(mul_hi_r, mul_lo_r);
    assign div_v = pair(div_hi_r, div_lo_r);
    assign pre_v = pair(pre_hi_r, pre_lo_r);
    assign main_v = pair(main_hi_r, main_lo_r);

    logic wr;
    logic [5:0] wa;
    logic [15:0] wd;
    logic cfg_ok;
    assign wr = req_i.wr & ce_i;
    assign wa = req_i.addr;
    assign wd = req_i.wdata;
    // counter and relay words bypass the permission setting
    assign cfg_ok = cfg_write_en_i;

    // ----------------
    // input filter
    // ----------------
    logic [FW-1:0] hold;
    always_comb begin
        // half a period of the highest passed frequency
        if (filt_r == 4'h0) begin
            hold = FW'(CLK_HZ / (2 * `FILT_FAST_HZ));
        end else begin
            hold = FW'(CLK_HZ / (2 * `FILT_BASE_HZ * int'(filt_r)));
        end
    end

    logic [2:0] raw_in, flt;
    assign raw_in = {pins_i.aux, pins_i.b, pins_i.a};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filt
            pulse_filter #(.W(FW)) u_filt (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .ce_i(ce_i),
                .hold_i(hold),
                .in_i(raw_in[gi]),
                .out_o(flt[gi])
            );
        end
    endgenerate

    logic a_d, b_d;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            a_d <= 1'b0;
            b_d <= 1'b0;
        end else if (ce_i) begin
            a_d <= flt[0];
            b_d <= flt[1];
        end
    end

    // ----------------
    // counting events
    // ----------------
    logic a_rise, b_rise, a_chg, b_chg;
    assign a_rise = flt[0] & ~a_d;
    assign b_rise = flt[1] & ~b_d;
    assign a_chg = flt[0] ^ a_d;
    assign b_chg = flt[1] ^ b_d;

    // ev_up / ev_dn: counts of +1 and -1 events this cycle
    logic [1:0] ev_up, ev_dn;
    always_comb begin
        ev_up = 2'h0;
        ev_dn = 2'h0;
        case (func_r)
            FN_ADD: begin
                ev_up = 2'(a_rise) + 2'(b_rise);
            end
            FN_SUB: begin
                ev_up = 2'(a_rise);
                ev_dn = 2'(b_rise);
            end
            FN_QUAD1: begin
                // one step per full cycle: rising a edge counts up, falling a edge counts down, both only with b low
                if (a_rise && !flt[1]) ev_up = 2'h1;
                if (a_chg && !flt[0] && !flt[1]) ev_dn = 2'h1;
            end
            FN_QUAD4: begin
                // both edges of both phases; a double change is an error
                if (a_chg ^ b_chg) begin
                    if (a_chg ? (flt[0] ^ flt[1]) : !(flt[0] ^ flt[1])) begin
                        ev_up = 2'h1;
                    end else begin
                        ev_dn = 2'h1;
                    end
                end
            end
            default: begin
                ev_up = 2'h0;
            end
        endcase
        if (aux_fn_r == AUX_DIR && flt[2]) begin
            {ev_up, ev_dn} = {ev_dn, ev_up};
        end
        if (aux_fn_r == AUX_HOLD && flt[2]) begin
            ev_up = 2'h0;
            ev_dn = 2'h0;
        end
    end

    // ----------------
    // precounter and main counter
    // ----------------
    logic clr_src;
    always_comb begin
        case (clr_sel_r)
            2'h0: clr_src = pins_i.ext_clear | pins_i.button_clear;
            2'h1: clr_src = pins_i.ext_clear;
            2'h2: clr_src = pins_i.button_clear;
            default: clr_src = 1'b0;
        endcase
    end

    logic signed [31:0] pre_nxt, main_nxt, net;
    always_comb begin
        net = 32'(ev_up) - 32'(ev_dn);
        pre_nxt = pre_v + net;
        main_nxt = main_v;
        // precounter wraps modulo divider, each wrap steps main
        if (pre_nxt >= div_v) begin
            pre_nxt = pre_nxt - div_v;
            main_nxt = main_v + 32'sd1;
        end else if (pre_nxt < 0) begin
            pre_nxt = pre_nxt + div_v;
            main_nxt = main_v - 32'sd1;
        end
        if (clr_src || (auto_clr_r && auto_clear_i)) begin
            main_nxt = 32'sd0;
            pre_nxt = 32'sd0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_hi_r <= 16'h0000;
            pre_lo_r <= 16'h0000;
            main_hi_r <= 16'h0000;
            main_lo_r <= 16'h0000;
        end else if (ce_i) begin
            {pre_hi_r, pre_lo_r} <= pre_nxt;
            {main_hi_r, main_lo_r} <= main_nxt;
            // bus writes take precedence over counting in the same cycle
            if (wr) begin
                case (wa)
                    `REG_PRE_HI: pre_hi_r <= wd;
                    `REG_PRE_LO: pre_lo_r <= wd;
                    `REG_MAIN_HI: main_hi_r <= wd;
                    `REG_MAIN_LO: main_lo_r <= wd;
                    default: begin
                        // other words leave counting untouched
                    end
                endcase
            end
        end
    end

    // ----------------
    // relays
    // ----------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            relay_o <= 4'h0;
            task_r <= 4'h0;
        end else if (ce_i) begin
            relay_o <= relay_o | relay_fire_i;
            if (wr && wa == `REG_RELAY) begin
                relay_o <= wd[3:0] | relay_fire_i;
            end
            // set wins: on a clear, only a relay active in that cycle keeps its bit
            task_r <= task_r | relay_o | relay_fire_i;
            if (clr_src) task_r <= relay_o | relay_fire_i;
        end
    end

    // ----------------
    // configuration writes
    // ----------------
    logic signed [31:0] mul_try, div_try;
    logic reject;
    always_comb begin
        mul_try = mul_v;
        div_try = div_v;
        reject = 1'b0;
        if (wa == `REG_MUL_HI) mul_try = pair(wd, mul_lo_r);
        if (wa == `REG_MUL_LO) mul_try = pair(mul_hi_r, wd);
        if (wa == `REG_DIV_HI) div_try = pair(wd, div_lo_r);
        if (wa == `REG_DIV_LO) div_try = pair(div_hi_r, wd);
        case (wa)
            `REG_AUX_FN: reject = wd > `AUX_MAX;
            `REG_CLR_SEL: reject = wd > `CLR_MAX;
            `REG_AUTO_CLR: reject = wd > `AUTO_MAX;
            `REG_FILTER: reject = wd > `FILT_MAX;
            `REG_FUNC: reject = wd > `FUNC_MAX;
            `REG_MUL_HI, `REG_MUL_LO:
                reject = !in_range(mul_try, `MUL_MIN, `MUL_MAX);
            `REG_DIV_HI, `REG_DIV_LO:
                reject = !in_range(div_try, `DIV_MIN, `DIV_MAX);
            `REG_SHOWN_HI, `REG_SHOWN_LO, `REG_STATUS, `REG_TASK:
                reject = 1'b1;
            `REG_PRE_HI, `REG_PRE_LO, `REG_MAIN_HI, `REG_MAIN_LO,
            `REG_RELAY:
                reject = 1'b0;
            default: reject = 1'b1;
        endcase
        if (!cfg_ok && wa >= `REG_AUX_FN) reject = 1'b1;
    end

    // limitation: a 32-bit pair written word by word must pass the range
    // check after each word, so order the words to stay in range
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aux_fn_r <= AUX_OFF;
            func_r <= FN_ADD;
            clr_sel_r <= 2'h0;
            auto_clr_r <= 1'b0;
            filt_r <= 4'h0;
            {mul_hi_r, mul_lo_r} <= `MUL_RESET;
            {div_hi_r, div_lo_r} <= `DIV_RESET;
            wr_reject_o <= 1'b0;
        end else if (ce_i) begin
            wr_reject_o <= wr & reject;
            if (wr && !reject) begin
                case (wa)
                    `REG_AUX_FN: aux_fn_r <= aux_fn_t'(wd[1:0]);
                    `REG_CLR_SEL: clr_sel_r <= wd[1:0];
                    `REG_AUTO_CLR: auto_clr_r <= wd[0];
                    `REG_FILTER: filt_r <= wd[3:0];
                    `REG_FUNC: func_r <= count_fn_t'(wd[1:0]);
                    `REG_MUL_HI: mul_hi_r <= wd;
                    `REG_MUL_LO: mul_lo_r <= wd;
                    `REG_DIV_HI: div_hi_r <= wd;
                    `REG_DIV_LO: div_lo_r <= wd;
                    default: begin
                        filt_r <= filt_r;
                    end
                endcase
            end
        end
    end

    // ----------------
    // shown value and read port
    // ----------------
    logic signed [63:0] scaled;
    logic signed [31:0] shown;
    logic [15:0] status;
    assign scaled = (64'(main_v) * 64'(mul_v)) / 64'(div_v);
    always_comb begin
        shown = scaled[31:0];
        status = `STATUS_VALID;
        if (scaled > `SHOWN_MAX) begin
            status = `STATUS_OVER;
            shown = `MUL_MAX;
        end else if (scaled < `SHOWN_MIN) begin
            status = `STATUS_UNDER;
            shown = `MUL_MIN;
        end
    end

    logic [15:0] rd_mux;
    always_comb begin
        case (req_i.addr)
            `REG_SHOWN_HI: rd_mux = shown[31:16];
            `REG_SHOWN_LO: rd_mux = shown[15:0];
            `REG_STATUS: rd_mux = status;
            `REG_PRE_HI: rd_mux = pre_hi_r;
            `REG_PRE_LO: rd_mux = pre_lo_r;
            `REG_MAIN_HI: rd_mux = main_hi_r;
            `REG_MAIN_LO: rd_mux = main_lo_r;
            `REG_RELAY: rd_mux = {12'h000, relay_o};
            `REG_TASK: rd_mux = {12'h000, task_r};
            `REG_AUX_FN: rd_mux = {14'h0000, aux_fn_r};
            `REG_CLR_SEL: rd_mux = {14'h0000, clr_sel_r};
            `REG_AUTO_CLR: rd_mux = {15'h0000, auto_clr_r};
            `REG_FILTER: rd_mux = {12'h000, filt_r};
            `REG_FUNC: rd_mux = {14'h0000, func_r};
            `REG_MUL_HI: rd_mux = mul_hi_r;
            `REG_MUL_LO: rd_mux = mul_lo_r;
            `REG_DIV_HI: rd_mux = div_hi_r;
            `REG_DIV_LO: rd_mux = div_lo_r;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
        end else if (ce_i) begin
            rvalid_o <= req_i.rd;
            if (req_i.rd) rdata_o <= rd_mux;
        end
    end
endmodule : pulse_counter

// *** pulse_counter_assertions.sv ***
`timescale 1ns/100ps
`include "pulse_counter_params.svh"
module pulse_counter_assertions
    import pulse_counter_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire pulse_counter_pkg::reg_req_t req_i,
    input wire logic cfg_write_en_i,
    input wire logic [3:0] relay_fire_i,
    input wire logic [15:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic wr_reject_o,
    input wire logic [3:0] relay_o
);
    // ----------------
    // register access checks
    // ----------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    logic take_wr;
    logic take_rd;
    assign take_wr = ce_i && req_i.wr;
    assign take_rd = ce_i && req_i.rd;
    AST_RD_ANSWER: assert property (take_rd |=> rvalid_o)
        else $error("read not answered");
    AST_RVALID_CAUSE: assert property (rvalid_o |-> $past(take_rd))
        else $error("read answer without request");
    AST_RO_REFUSED: assert property (take_wr && req_i.addr inside
        {`REG_SHOWN_HI, `REG_SHOWN_LO, `REG_STATUS} |=> wr_reject_o)
        else $error("read-only write accepted");
    AST_STATUS_CODE: assert property (rvalid_o
        && $past(req_i.addr) == `REG_STATUS |-> rdata_o inside
        {`STATUS_VALID, `STATUS_OVER, `STATUS_UNDER})
        else $error("bad status code");
    AST_RELAY_FIELD: assert property (rvalid_o
        && $past(req_i.addr) == `REG_RELAY |-> rdata_o[15:4] == 12'h000)
        else $error("relay register upper bits set");
    AST_RELAY_DRIVE: assert property (take_wr && req_i.addr == `REG_RELAY
        && relay_fire_i == 4'h0 |=> relay_o == $past(req_i.wdata[3:0]))
        else $error("relay pins do not follow write");
    AST_TASK_RO: assert property (take_wr && req_i.addr == `REG_TASK
        |=> wr_reject_o ##1 !wr_reject_o || $past(take_wr))
        else $error("task register write accepted");
    AST_AUX_RANGE: assert property (take_wr && req_i.addr == `REG_AUX_FN
        && req_i.wdata > `AUX_MAX |=> wr_reject_o)
        else $error("aux mode out of range accepted");
    AST_CLR_RANGE: assert property (take_wr && req_i.addr == `REG_CLR_SEL
        && req_i.wdata > `CLR_MAX |=> wr_reject_o)
        else $error("clear source out of range accepted");
    AST_AUTO_RANGE: assert property (take_wr
        && req_i.addr == `REG_AUTO_CLR && req_i.wdata > `AUTO_MAX
        |=> wr_reject_o) else $error("auto clear out of range accepted");
    AST_FILT_RANGE: assert property (take_wr && req_i.addr == `REG_FILTER
        && req_i.wdata > `FILT_MAX |=> wr_reject_o)
        else $error("filter code out of range accepted");
    AST_FUNC_RANGE: assert property (take_wr && req_i.addr == `REG_FUNC
        && req_i.wdata > `FUNC_MAX |=> wr_reject_o)
        else $error("function code out of range accepted");
    AST_COUNTER_OPEN: assert property (take_wr && !cfg_write_en_i
        && req_i.addr inside {[`REG_PRE_HI:`REG_RELAY]} |=> !wr_reject_o)
        else $error("counter write refused while locked");
    COV_READ: cover property (take_rd ##1 rvalid_o);
    COV_REJECT: cover property (take_wr ##1 wr_reject_o);
    COV_RELAY: cover property (relay_o != 4'h0);
endmodule : pulse_counter_assertions

// *** pulse_source.sv ***
`timescale 1ns/100ps
// ----------------
// pulse sensor model, moves only on falling edges
// ----------------
module pulse_source (
    input wire logic clk_i,
    output logic a_o,
    output logic b_o
);
    initial begin
        a_o = 1'b0;
        b_o = 1'b0;
    end
    task automatic step(input logic a, input logic b, input int len);
        @(negedge clk_i);
        a_o = a;
        b_o = b;
        repeat (len - 1) @(negedge clk_i);
    endtask : step
    // kind 0 pulses a, kind 1 pulses b, else one forward quadrature cycle
    task automatic run(input int kind, input int n, input int len);
        for (int i = 0; i < n; i++) begin
            if (kind == 0) begin
                step(1'b1, 1'b0, len);
            end else if (kind == 1) begin
                step(1'b0, 1'b1, len);
            end else begin
                step(1'b1, 1'b0, len);
                step(1'b1, 1'b1, len);
                step(1'b0, 1'b1, len);
            end
            step(1'b0, 1'b0, len);
        end
    endtask : run
endmodule : pulse_source

// *** tb_pulse_counter_register_map.sv ***
`timescale 1ns/100ps
`include "pulse_counter_params.svh"
module tb_pulse_counter_register_map;
    import pulse_counter_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    reg_req_t req_i = '0;
    pulse_in_t pins_i;
    logic cfg_write_en_i = 1'b1;
    logic ce_r = 1'b1;
    logic auto_clear_i = 1'b0;
    logic [3:0] relay_fire_i = 4'h0;
    logic [15:0] rdata_o;
    logic rvalid_o;
    logic wr_reject_o;
    logic [3:0] relay_o;
    logic a_w;
    logic b_w;
    logic aux_r = 1'b0;
    logic ext_r = 1'b0;
    logic btn_r = 1'b0;
    int n_mismatch = 0;
    int check_count = 0;
    always #5 clk_i = ~clk_i;
    assign pins_i = {a_w, b_w, aux_r, ext_r, btn_r};
    // a short clock base keeps the code 0 filter hold at 2 cycles
    pulse_counter #(.CLK_HZ(40000)) dut_u (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_r),
        .req_i(req_i),
        .pins_i(pins_i),
        .cfg_write_en_i(cfg_write_en_i),
        .auto_clear_i(auto_clear_i),
        .relay_fire_i(relay_fire_i),
        .rdata_o(rdata_o),
        .rvalid_o(rvalid_o),
        .wr_reject_o(wr_reject_o),
        .relay_o(relay_o)
    );
    pulse_source src_u (
        .clk_i(clk_i),
        .a_o(a_w),
        .b_o(b_w)
    );
    // ----------------
    // shared tasks
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic settle;
        repeat (12) @(negedge clk_i);
    endtask : settle
    task automatic bus(input logic w, input logic [5:0] a,
            input logic [15:0] d, output logic [15:0] r, output logic j);
        @(negedge clk_i);
        req_i = {w, ~w, a, d};
        @(negedge clk_i);
        req_i = '0;
        r = rdata_o;
        j = wr_reject_o;
        if (!w) check(rvalid_o, 1'b1, "read answer");
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [15:0] d,
            input logic rej);
        logic [15:0] r;
        logic j;
        bus(1'b1, a, d, r, j);
        check(j, rej, "write refusal");
    endtask : wr
    task automatic get(input logic [5:0] a, output logic [15:0] r);
        logic j;
        bus(1'b0, a, 16'h0000, r, j);
    endtask : get
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] r;
        get(a, r);
        check(r, e, "read data");
    endtask : rd
    task automatic rd32(input logic [5:0] a, input logic [31:0] e);
        rd(a, e[31:16]);
        rd(a + 6'h01, e[15:0]);
    endtask : rd32
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset;
        rd32(`REG_MUL_HI, `MUL_RESET);
        rd32(`REG_DIV_HI, `DIV_RESET);
        rd32(`REG_MAIN_HI, 32'h0);
        rd(`REG_STATUS, `STATUS_VALID);
    endtask : t_reset
    task automatic t_readonly;
        logic [5:0] ad[6] = '{`REG_SHOWN_HI, `REG_SHOWN_LO, `REG_STATUS,
            `REG_TASK, 6'h0a, 6'h10};
        foreach (ad[i]) wr(ad[i], 16'h1234, 1'b1);
        rd(6'h0a, 16'h0000);
        rd32(`REG_SHOWN_HI, 32'h0);
    endtask : t_readonly
    task automatic t_ranges;
        logic [5:0] ad[5] = '{`REG_AUX_FN, `REG_CLR_SEL, `REG_AUTO_CLR,
            `REG_FILTER, `REG_FUNC};
        logic [15:0] mx[5] = '{`AUX_MAX, `CLR_MAX, `AUTO_MAX, `FILT_MAX,
            `FUNC_MAX};
        for (int i = 0; i < 5; i++) begin
            wr(ad[i], mx[i] + 16'h0001, 1'b1);
            rd(ad[i], 16'h0000);
            wr(ad[i], mx[i], 1'b0);
            rd(ad[i], mx[i]);
            wr(ad[i], 16'h0000, 1'b0);
        end
        cfg_write_en_i = 1'b0;
        wr(`REG_AUX_FN, 16'h0001, 1'b1);
        wr(`REG_MAIN_LO, 16'h0005, 1'b0);
        ce_r = 1'b0;
        wr(`REG_MAIN_LO, 16'h0009, 1'b0);
        ce_r = 1'b1;
        rd(`REG_MAIN_LO, 16'h0005);
        cfg_write_en_i = 1'b1;
    endtask : t_ranges
    task automatic t_relay;
        logic [15:0] r;
        wr(`REG_RELAY, 16'hfffa, 1'b0);
        check(relay_o, 4'ha, "relay pins");
        rd(`REG_RELAY, 16'h000a);
        wr(`REG_RELAY, 16'h0000, 1'b0);
        relay_fire_i = 4'h4;
        settle;
        check(relay_o[2], 1'b1, "fired relay");
        relay_fire_i = 4'h0;
        get(`REG_TASK, r);
        check(r[2], 1'b1, "task bit");
        wr(`REG_RELAY, 16'h0000, 1'b0);
        check(relay_o, 4'h0, "relays off");
    endtask : t_relay
    task automatic t_count;
        int fn[5] = '{0, 1, 1, 3, 2};
        int kd[5] = '{1, 1, 0, 2, 2};
        int np[5] = '{2, 3, 1, 2, 3};
        int ex[5] = '{2, -1, 0, 8, 11};
        wr(`REG_MAIN_LO, 16'h0000, 1'b0);
        wr(`REG_DIV_LO, 16'h0000, 1'b1);
        wr(`REG_DIV_LO, 16'h0003, 1'b0);
        src_u.run(0, 7, 8);
        settle;
        rd32(`REG_MAIN_HI, 32'd2);
        rd32(`REG_PRE_HI, 32'd1);
        wr(`REG_DIV_LO, 16'h0001, 1'b0);
        wr(`REG_PRE_LO, 16'h0000, 1'b0);
        wr(`REG_MAIN_LO, 16'h0000, 1'b0);
        for (int i = 0; i < 5; i++) begin
            wr(`REG_FUNC, 16'(fn[i]), 1'b0);
            src_u.run(kd[i], np[i], 8);
            settle;
            rd32(`REG_MAIN_HI, 32'(ex[i]));
        end
        wr(`REG_FUNC, 16'h0000, 1'b0);
    endtask : t_count
    task automatic t_clear;
        for (int c = 0; c < 4; c++) begin
            wr(`REG_CLR_SEL, 16'(c), 1'b0);
            for (int p = 0; p < 2; p++) begin
                wr(`REG_MAIN_LO, 16'h0007, 1'b0);
                ext_r = (p == 0);
                btn_r = (p == 1);
                repeat (3) @(negedge clk_i);
                ext_r = 1'b0;
                btn_r = 1'b0;
                rd(`REG_MAIN_LO, (c == 0 || c == p + 1) ? 16'h0 : 16'h7);
            end
        end
        for (int e = 0; e < 2; e++) begin
            wr(`REG_AUTO_CLR, 16'(e), 1'b0);
            wr(`REG_MAIN_LO, 16'h0007, 1'b0);
            auto_clear_i = 1'b1;
            repeat (3) @(negedge clk_i);
            auto_clear_i = 1'b0;
            rd(`REG_MAIN_LO, (e == 1) ? 16'h0000 : 16'h0007);
        end
        wr(`REG_AUTO_CLR, 16'h0000, 1'b0);
    endtask : t_clear
    task automatic t_aux_filter;
        wr(`REG_MAIN_LO, 16'h0000, 1'b0);
        wr(`REG_FILTER, 16'h0009, 1'b0);
        src_u.run(0, 2, 8);
        settle;
        rd(`REG_MAIN_LO, 16'h0000);
        wr(`REG_FILTER, 16'h0000, 1'b0);
        wr(`REG_AUX_FN, 16'h0001, 1'b0);
        aux_r = 1'b1;
        settle;
        src_u.run(0, 2, 8);
        settle;
        rd(`REG_MAIN_LO, 16'h0000);
        wr(`REG_AUX_FN, 16'h0002, 1'b0);
        src_u.run(0, 2, 8);
        settle;
        rd32(`REG_MAIN_HI, 32'hffff_fffe);
        aux_r = 1'b0;
        wr(`REG_AUX_FN, 16'h0000, 1'b0);
    endtask : t_aux_filter
    task automatic t_scale;
        wr(`REG_MUL_LO, 16'h0005, 1'b0);
        wr(`REG_DIV_LO, 16'h0003, 1'b0);
        wr(`REG_MAIN_HI, 16'h0000, 1'b0);
        wr(`REG_MAIN_LO, 16'h000c, 1'b0);
        settle;
        rd32(`REG_SHOWN_HI, 32'd20);
        rd(`REG_STATUS, `STATUS_VALID);
        wr(`REG_MAIN_HI, 16'h0010, 1'b0);
        wr(`REG_MAIN_LO, 16'h0000, 1'b0);
        settle;
        rd32(`REG_SHOWN_HI, 32'h000f_423f);
        rd(`REG_STATUS, `STATUS_OVER);
        wr(`REG_MAIN_HI, 16'hfff0, 1'b0);
        settle;
        rd32(`REG_SHOWN_HI, 32'hfffe_7961);
        rd(`REG_STATUS, `STATUS_UNDER);
        wr(`REG_MUL_HI, 16'h0010, 1'b1);
        wr(`REG_MUL_HI, 16'h000f, 1'b0);
        rd32(`REG_MUL_HI, 32'h000f_0005);
        wr(`REG_DIV_HI, 16'h0010, 1'b1);
    endtask : t_scale
    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_reset;
        t_readonly;
        t_ranges;
        t_relay;
        t_count;
        t_clear;
        t_aux_filter;
        t_scale;
        close_out;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out;
    end
endmodule : tb_pulse_counter_register_map
bind pulse_counter pulse_counter_assertions chk_u (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .req_i(req_i),
    .cfg_write_en_i(cfg_write_en_i),
    .relay_fire_i(relay_fire_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .wr_reject_o(wr_reject_o),
    .relay_o(relay_o)
);
